// ### hdl/adcc_conversion_control.sv
// Purpose: control register and start logic for an on-chip converter
// Assumes: core answers each start with one done pulse; avalon-mm slave
// Notes:   status register shows power, settle, busy and continuous state
//
// Behaviour
// R1 - power bit set puts converter in normal mode
// R2 - software waits 5 us after power-up
// R3 - power bit clear powers the converter down
// R4 - mode field selects single, differential, pseudo
// R5 - select 000 starts from external pin
// R6 - select 001 starts from timer one
// R7 - select 010 starts from timer zero
// R8 - select 011 single conversion, then reverts 000
// R9 - software clears enable after single start
// R10 - select 100 continuous, 101 logic array
// R11 - enable gates starts, not running continuous
// R12 - selects 110, 111 start nothing
`timescale 1ns/1ps

module adcc_conversion_control (
  input  wire logic               clk,
  input  wire logic               reset,
  // avalon-mm slave
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // trigger sources
  input  wire adcc_pkg::adcc_trig_t trig,
  // converter core
  input  wire logic               core_done,
  output logic                    core_power_on,
  output adcc_pkg::adcc_mode_t    core_input_mode,
  output logic                    core_start
);
  import adcc_pkg::*;

  logic [15:0]          ctrl;
  logic [15:0]          next_ctrl;
  logic [2:0]           pin_sync;
  logic                 pin_level;
  logic                 busy;
  logic                 cont_run;
  logic                 single_pend;
  logic                 single_act;
  logic [PWR_CNT_W-1:0] pwr_cnt;
  logic                 pwr_ready;

  // bus decode
  wire req       = avs_read | avs_write;
  wire accept    = req & ~avs_waitrequest;
  wire hit_ctrl  = avs_address == CTRL_OFFSET;
  wire hit_stat  = avs_address == STATUS_OFFSET;
  wire wr_ctrl   = accept & avs_write & hit_ctrl;
  wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [15:0] wr_val  = avs_writedata[15:0] & CTRL_RW_MASK;

  // control fields
  wire                 en       = ctrl[START_EN_BIT];
  wire                 pwr      = ctrl[POWER_BIT];
  wire [1:0]           mode_fld = ctrl[MODE_LSB +: 2];
  wire adcc_trig_sel_t sel      = adcc_trig_sel_t'(ctrl[SEL_LSB +: 3]);

  // pin change counts once second and third stages agree
  wire pin_agree = pin_sync[1] == pin_sync[2];
  wire pin_rise  = pin_agree & pin_sync[2] & ~pin_level;

  // R5 pin source
  // R6 timer one
  // R7 timer zero
  // R10 continuous and array
  // R12 reserved selects
  logic src_event;
  always_comb begin
    unique case (sel)
      TRIG_PIN:    src_event = pin_rise;
      TRIG_GENERAL_TIMER_ONE: src_event = trig.general_timer_one;
      TRIG_GENERAL_TIMER_ZERO: src_event = trig.general_timer_zero;
      TRIG_SINGLE: src_event = single_pend;
      TRIG_CONT:   src_event = 1'b1;
      TRIG_PLA:    src_event = trig.programmable_logic_array_trigger;
      TRIG_RES6:   src_event = 1'b0;
      TRIG_RES7:   src_event = 1'b0;
    endcase
  end

  // R11 enable gate
  // a running continuous loop restarts even with enable cleared
  wire idle       = pwr & ~busy & ~core_start;
  wire start_cond = idle & ((en & src_event) | (cont_run & sel == TRIG_CONT));

  // R8 revert after single
  wire revert = single_act & core_done;

  // control next value: bus write lands after the revert, so it wins
  always_comb begin
    next_ctrl = ctrl;
    if (revert)
      next_ctrl[SEL_LSB +: 3] = TRIG_PIN;
    if (wr_ctrl)
      next_ctrl = (ctrl & ~be_mask) | (wr_val & be_mask);
  end

  // R1 power up
  // R3 power down
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl          <= CTRL_RESET;
      core_power_on <= 1'b0;
    end else begin
      ctrl          <= next_ctrl;
      core_power_on <= next_ctrl[POWER_BIT];
    end
  end

  // R4 mode select
  // reserved code keeps the last legal mode at the core
  always_ff @(posedge clk) begin
    if (reset)
      core_input_mode <= MODE_SINGLE_ENDED;
    else if (next_ctrl[MODE_LSB +: 2] != MODE_RESERVED)
      core_input_mode <= adcc_mode_t'(next_ctrl[MODE_LSB +: 2]);
  end

  // pin synchroniser, first stage read only by second
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_sync  <= 3'b000;
      pin_level <= 1'b0;
    end else begin
      pin_sync  <= {pin_sync[1:0], trig.external_convert_pin};
      if (pin_agree)
        pin_level <= pin_sync[2];
    end
  end

  // start pulse and busy tracking
  always_ff @(posedge clk) begin
    if (reset) begin
      core_start <= 1'b0;
      busy       <= 1'b0;
    end else begin
      core_start <= start_cond;
      if (core_start)
        busy <= 1'b1;
      else if (core_done | ~pwr)
        busy <= 1'b0;
    end
  end

  // R10 continuous loop
  // power-down or a new select ends the loop
  always_ff @(posedge clk) begin
    if (reset)
      cont_run <= 1'b0;
    else if (~pwr | sel != TRIG_CONT)
      cont_run <= 1'b0;
    else if (start_cond)
      cont_run <= 1'b1;
  end

  // R8 single conversion
  // request armed by each write of select 011
  always_ff @(posedge clk) begin
    if (reset) begin
      single_pend <= 1'b0;
      single_act  <= 1'b0;
    end else begin
      if (wr_ctrl & next_ctrl[SEL_LSB +: 3] == TRIG_SINGLE)
        single_pend <= 1'b1;
      else if (start_cond | sel != TRIG_SINGLE)
        single_pend <= 1'b0;
      if (start_cond & sel == TRIG_SINGLE)
        single_act <= 1'b1;
      else if (core_done | ~pwr)
        single_act <= 1'b0;
    end
  end

  // R2 settle indicator
  // hardware does not hold off starts; software polls ready
  always_ff @(posedge clk) begin
    if (reset | ~pwr) begin
      pwr_cnt   <= '0;
      pwr_ready <= 1'b0;
    end else if (pwr_cnt != PWR_CNT_W'(POWERUP_CYCLES)) begin
      pwr_cnt   <= pwr_cnt + 1'b1;
    end else begin
      pwr_ready <= 1'b1;
    end
  end

  // read mux, unmapped reads zero
  wire [31:0] stat_word = {28'h000_0000, cont_run, busy, pwr_ready, pwr};
  wire [31:0] rd_word   = hit_ctrl ? {16'h0000, ctrl} :
                          hit_stat ? stat_word : 32'h0000_0000;

  // one wait cycle per access, answer registered
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req & avs_waitrequest)
        avs_readdata  <= rd_word;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // bus one wait cycle
  bus_answer_a: assert property ( // bus
    req & avs_waitrequest |=> ~avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

  // R1 power on after set
  power_up_a: assert property ( // R1
    wr_ctrl & avs_byteenable[0] & avs_writedata[POWER_BIT] |=> core_power_on)
    else $error("converter not powered after power bit write");

  // R3 power off, no start
  power_down_a: assert property ( // R3
    wr_ctrl & avs_byteenable[0] & ~avs_writedata[POWER_BIT]
    |=> ~core_power_on ##1 ~core_start)
    else $error("converter not powered down after clear");

  // R4 reserved mode blocked
  mode_hold_a: assert property ( // R4
    mode_fld == MODE_RESERVED |-> core_input_mode != MODE_RESERVED)
    else $error("reserved mode reached the core");

  // R5 pin edge starts
  pin_start_a: assert property ( // R5
    pin_rise & sel == TRIG_PIN & en & idle |=> core_start)
    else $error("pin edge did not start conversion");

  // R6 timer one source
  timer_start_a: assert property ( // R6
    core_start & $past(sel) == TRIG_GENERAL_TIMER_ONE |-> $past(trig.general_timer_one))
    else $error("timer one start without timer pulse");

  // R8 select reverts to pin
  single_revert_a: assert property ( // R8
    revert & ~wr_ctrl |=> sel == TRIG_PIN)
    else $error("single select did not revert");

  // R10 loop restarts itself
  cont_restart_a: assert property ( // R10
    cont_run & sel == TRIG_CONT & idle |=> core_start ##1 busy)
    else $error("continuous loop did not restart");

  // R11 enable gates starts
  enable_gate_a: assert property ( // R11
    core_start & ~$past(en) |-> $past(cont_run))
    else $error("start while enable clear");

  // R12 reserved select idle
  reserved_sel_a: assert property ( // R12
    sel == TRIG_RES6 | sel == TRIG_RES7 |=> ~core_start)
    else $error("start under reserved select");

  // R1 power output tracks bit
  power_follow_a: assert property ( // R1
    core_power_on == pwr)
    else $error("power output differs from power bit");

  // R3 no start when off
  powered_off_a: assert property ( // R3
    ~pwr |=> ~core_start)
    else $error("start while powered down");

  // R4 legal mode reaches core
  mode_follow_a: assert property ( // R4
    mode_fld != MODE_RESERVED |-> core_input_mode == mode_fld)
    else $error("core mode differs from mode field");

  // R5 pin start needs edge
  pin_only_a: assert property ( // R5
    core_start & $past(sel) == TRIG_PIN |-> $past(pin_rise))
    else $error("pin start without pin edge");

  // R6 timer one pulse starts
  timer_fire_a: assert property ( // R6
    sel == TRIG_GENERAL_TIMER_ONE & en & idle & trig.general_timer_one |=> core_start)
    else $error("timer one pulse did not start conversion");

  // R7 timer zero source
  timer_zero_a: assert property ( // R7
    core_start & $past(sel) == TRIG_GENERAL_TIMER_ZERO |-> $past(trig.general_timer_zero))
    else $error("timer zero start without timer pulse");

  // R8 pending single starts
  single_start_a: assert property ( // R8
    single_pend & sel == TRIG_SINGLE & en & idle |=> core_start)
    else $error("single conversion did not start");

  // R10 array pulse source
  array_start_a: assert property ( // R10
    core_start & $past(sel) == TRIG_PLA |-> $past(trig.programmable_logic_array_trigger))
    else $error("array start without array pulse");

  // R11 enable blocks starts
  enable_block_a: assert property ( // R11
    ~en & ~cont_run |=> ~core_start)
    else $error("start with enable clear and no loop");

  // core start is one cycle
  start_pulse_a: assert property ( // core
    core_start |=> ~core_start & busy)
    else $error("start not a single pulse into busy");

endmodule // adcc_conversion_control

// ### hdl/adcc_pkg.sv
// Purpose: constants and types for the converter control block
// Assumes: 200 MHz clock, 32-bit avalon-mm register port
// Notes:   offsets are byte addresses of aligned words
package adcc_pkg;

  // register map
  localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET = 4'h4;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_RW_MASK  = 16'hFFBF; // bit 6 reserved, reads zero

  // control field positions
  localparam int START_EN_BIT = 7;
  localparam int POWER_BIT    = 5;
  localparam int MODE_LSB     = 3;
  localparam int SEL_LSB      = 0;

  // status field positions
  localparam int ST_POWERED = 0;
  localparam int ST_READY   = 1;
  localparam int ST_BUSY    = 2;
  localparam int ST_CONT    = 3;

  // power-up settling, least time rounds up
  localparam int CLK_PERIOD_PS = 5000;
  localparam int POWERUP_US    = 5;
  localparam int POWERUP_CYCLES =
    (POWERUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PWR_CNT_W = $clog2(POWERUP_CYCLES + 1);

  // input mode field
  typedef enum logic [1:0] {
    MODE_SINGLE_ENDED = 2'b00,
    MODE_DIFFERENTIAL = 2'b01,
    MODE_PSEUDO_DIFF  = 2'b10,
    MODE_RESERVED     = 2'b11
  } adcc_mode_t;

  // conversion trigger select field
  typedef enum logic [2:0] {
    TRIG_PIN    = 3'b000,
    TRIG_GENERAL_TIMER_ONE = 3'b001,
    TRIG_GENERAL_TIMER_ZERO = 3'b010,
    TRIG_SINGLE = 3'b011,
    TRIG_CONT   = 3'b100,
    TRIG_PLA    = 3'b101,
    TRIG_RES6   = 3'b110,
    TRIG_RES7   = 3'b111
  } adcc_trig_sel_t;

  // trigger sources from outside the block
  typedef struct packed {
    logic external_convert_pin;             // asynchronous pin
    logic general_timer_zero;               // one-cycle pulse, clk domain
    logic general_timer_one;                // one-cycle pulse, clk domain
    logic programmable_logic_array_trigger; // one-cycle pulse, clk domain
  } adcc_trig_t;

endpackage : adcc_pkg

// ### verification/adcc_core_model.sv
// Purpose: converter core stand-in for the control block
// Assumes: one done pulse answers each start
// Notes:   latency alternates short and long
`timescale 1ns/1ps
module adcc_core_model (
  input  wire logic clk,
  input  wire logic core_start,
  output logic      core_done
);
  int   cnt  = 0;
  logic slow = 1'b0;
  // count down from each start; slow and prompt answers alternate
  always_ff @(posedge clk) begin
    core_done <= (cnt == 1);
    if (core_start === 1'b1) begin
      cnt  <= slow ? 9 : 3;
      slow <= !slow;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule // adcc_core_model

// ### verification/adc_conversion_control_bench.sv
// Purpose: self-checking bench for the converter control block
// Assumes: core model answers every start
// Notes:   core starts are counted, not timed
`timescale 1ns/1ps
module adc_conversion_control_bench;
  import adcc_pkg::*;
  logic        clk = 0, reset = 1, rd = 0, wr = 0, wreq, done, pwr, start;
  logic [3:0]  addr = 4'h0, be = 4'hF;
  logic [31:0] wd = 32'h0000_0000, rdata, q;
  adcc_trig_t  trig = '0;
  adcc_mode_t  mode;
  int          errors = 0, check_count = 0, starts = 0, s0;
  always #2.5 clk = ~clk;
  // tally core starts
  always @(posedge clk) if (start === 1'b1) starts++;
  adcc_conversion_control adcc_conversion_control_i (.clk(clk), .reset(reset),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .trig(trig), .core_done(done), .core_power_on(pwr),
    .core_input_mode(mode), .core_start(start));
  adcc_core_model adcc_core_model_i (.clk(clk), .core_start(start), .core_done(done));
  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= {16'h0000, d};
    @(posedge clk);
    // no local limit: a hang is left to the watchdog
    while (wreq !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // pin held a few cycles so the synchroniser sees an edge
  task automatic pulse(input int s);
    @(posedge clk);
    trig[s] <= 1'b1;
    repeat (s == 3 ? 4 : 1) @(posedge clk);
    trig[s] <= 1'b0;
    repeat (14) @(posedge clk);
  endtask
  task automatic t_regs();
    bus(0, CTRL_OFFSET, 16'h0000);
    chk(q, {16'h0000, CTRL_RESET});
    bus(1, 4'h8, 16'hFFFF);
    bus(0, 4'h8, 16'h0000);
    chk(q, 32'h0000_0000);
    // bit 6 stays clear, upper byte is plain storage
    bus(1, CTRL_OFFSET, 16'hFF40);
    bus(0, CTRL_OFFSET, 16'h0000);
    chk(q, 32'h0000_FF00);
    // low lane only: upper byte must survive
    be <= 4'h1;
    bus(1, CTRL_OFFSET, 16'h0018);
    be <= 4'hF;
    bus(0, CTRL_OFFSET, 16'h0000);
    chk(q, 32'h0000_FF18);
    chk(mode, 0);
    $display("registers test done");
  endtask
  task automatic t_power();
    bus(1, CTRL_OFFSET, 16'h0020);
    repeat (3) @(negedge clk);
    chk(pwr, 1);
    bus(0, STATUS_OFFSET, 16'h0000);
    chk(q[1:0], 2'b01);
    repeat (1000) @(posedge clk);
    bus(0, STATUS_OFFSET, 16'h0000);
    chk(q[1:0], 2'b11);
    bus(1, CTRL_OFFSET, 16'h0000);
    repeat (3) @(negedge clk);
    chk(pwr, 0);
    $display("power test done");
  endtask
  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      bus(1, CTRL_OFFSET, 16'(32 + 8 * m));
      repeat (3) @(negedge clk);
      chk(mode, m == 3 ? 2 : m);
    end
    $display("mode test done");
  endtask
  task automatic t_single();
    s0 = starts;
    bus(1, CTRL_OFFSET, 16'h00A3);
    repeat (30) @(posedge clk);
    chk(starts - s0, 1);
    bus(0, CTRL_OFFSET, 16'h0000);
    chk(q, 32'h0000_00A0);
    bus(1, CTRL_OFFSET, 16'h0020);
    $display("single test done");
  endtask
  // each select except single and continuous against every source: only its own source starts
  task automatic t_trig();
    logic [2:0] sel [6] = '{0, 1, 2, 5, 6, 7};
    int         src [6] = '{3, 1, 2, 0, 9, 9};
    for (int i = 0; i < 6; i++) begin
      bus(1, CTRL_OFFSET, 16'h00A0 | 16'(sel[i]));
      for (int s = 0; s < 4; s++) begin
        s0 = starts;
        pulse(s);
        chk(starts - s0, s == src[i]);
      end
    end
    $display("trigger test done");
  endtask
  task automatic t_cont();
    s0 = starts;
    bus(1, CTRL_OFFSET, 16'h00A4);
    repeat (60) @(posedge clk);
    chk(starts - s0 > 3, 1);
    bus(0, STATUS_OFFSET, 16'h0000);
    chk({q[3], q[0]}, 2'b11);
    bus(1, CTRL_OFFSET, 16'h0024);
    s0 = starts;
    repeat (60) @(posedge clk);
    chk(starts - s0 > 3, 1);
    bus(1, CTRL_OFFSET, 16'h0021);
    repeat (20) @(posedge clk);
    s0 = starts;
    pulse(1);
    chk(starts - s0, 0);
    bus(0, STATUS_OFFSET, 16'h0000);
    chk(q[3], 0);
    $display("continuous test done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_power();
    t_mode();
    t_single();
    t_trig();
    t_cont();
    results();
  end
  // watchdog well beyond the expected run of under two thousand cycles
  initial begin
    #100us;
    errors++;
    results();
  end
endmodule // adc_conversion_control_bench
